/* File: hdl/share_burst_slave_arbiter.sv */
// Share-based arbiter, burst adapter and read return path for one slave.
// Assumes all inputs are synchronous to ref_clk; masters always accept
// returned read data.
`timescale 1ns/10ps
module share_burst_slave_arbiter
    import arb_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Static configuration
    input wire logic [NM-1:0][SHW-1:0] share_count,
    input wire logic [NM-1:0] master_pipelined,
    input wire logic slave_pipelined,
    input wire logic slave_fixed_latency,
    // Master ports
    input wire logic [NM-1:0][AW-1:0] m_address,
    input wire logic [NM-1:0] m_read,
    input wire logic [NM-1:0] m_write,
    input wire logic [NM-1:0][DW-1:0] m_writedata,
    input wire logic [NM-1:0][BEW-1:0] m_byteenable,
    input wire logic [NM-1:0][BCW-1:0] m_burstcount,
    output logic [NM-1:0] m_waitrequest,
    output logic [NM-1:0][DW-1:0] m_readdata,
    output logic [NM-1:0] m_readdatavalid,
    // Shared slave port
    output logic [AW-1:0] s_address,
    output logic s_read,
    output logic s_write,
    output logic [DW-1:0] s_writedata,
    output logic [BEW-1:0] s_byteenable,
    output logic [BCW-1:0] s_burstcount,
    input wire logic s_waitrequest,
    input wire logic [DW-1:0] s_readdata,
    input wire logic s_readdatavalid
);

// ============================================================
// Helpers
function automatic logic [IW-1:0] rr_pick(input logic [NM-1:0] req,
    input logic [IW-1:0] last);
    logic [IW-1:0] pick;
    int idx;
    pick = last;
    // Nearest requester after last wins; last itself comes final
    for (int k = NM; k >= 1; k--)
    begin
        idx = (int'(last) + k) % NM;
        if (req[idx])
            pick = IW'(idx);
    end
    return pick;
endfunction : rr_pick

function automatic logic [BCW-1:0] blen(input logic [BCW-1:0] bc);
    return (bc == '0) ? ONE_BC : bc;
endfunction : blen

function automatic logic [BCW-1:0] bmin(input logic [BCW-1:0] a,
    input logic [BCW-1:0] b);
    return (a < b) ? a : b;
endfunction : bmin

// ============================================================
// Declarations
arb_st_t st_r, st_nxt;
logic [IW-1:0] gnt_r, gnt_nxt;
logic [SHW-1:0] share_r, share_nxt;
logic [NM-1:0] wait_r, wait_nxt;
logic [BCW-1:0] wleft_r, wleft_nxt, rleft_r, rleft_nxt;
logic [BCW-1:0] piece_r, piece_nxt;
logic [AW-1:0] addr_r, addr_nxt, sa_r, sa_nxt;
logic sr_r, sr_nxt, sw_r, sw_nxt;
logic [DW-1:0] sd_r, sd_nxt;
logic [BEW-1:0] sbe_r, sbe_nxt;
logic [BCW-1:0] sbc_r, sbc_nxt;
logic [CW-1:0] pend_r, pend_nxt;
logic [FLAT-1:0] sh_r, sh_nxt;
logic [IW-1:0] tid_r [MAXP], tid_nxt [MAXP];
logic [BCW-1:0] tcnt_r [MAXP], tcnt_nxt [MAXP];
logic [PW-1:0] twp_r, twp_nxt, trp_r, trp_nxt;
logic [CW-1:0] tc_r, tc_nxt;
logic [DW-1:0] rf_r [NM][MAXP], rf_nxt [NM][MAXP];
logic [PW-1:0] rwp_r [NM], rwp_nxt [NM], rrp_r [NM], rrp_nxt [NM];
logic [CW-1:0] rc_r [NM], rc_nxt [NM];
logic [OW-1:0] mout_r [NM], mout_nxt [NM];
logic [NM-1:0] rv_r, rv_nxt;
logic [NM-1:0][DW-1:0] rd_r, rd_nxt;
logic [NM-1:0] req;
logic take, sfree, ret, issue, done;
logic [BCW-1:0] lim, bc, n;

// Outputs straight from flops
assign m_waitrequest = wait_r;
assign m_readdata = rd_r;
assign m_readdatavalid = rv_r;
assign s_address = sa_r;
assign s_read = sr_r;
assign s_write = sw_r;
assign s_writedata = sd_r;
assign s_byteenable = sbe_r;
assign s_burstcount = sbc_r;

// Handshake terms
assign req = m_read | m_write;
assign take = (st_r == ST_XFER) && !wait_r[gnt_r] && req[gnt_r];
assign sfree = !(sr_r || sw_r) || !s_waitrequest;
// Fixed-latency slaves have no valid strobe; the shift line stands in
assign ret = slave_fixed_latency ? sh_r[FLAT-1] : s_readdatavalid;
assign lim = slave_fixed_latency ? ONE_BC : SMAX;

// ============================================================
// Arbitration and burst adapter
always_comb
begin
    st_nxt = st_r;
    gnt_nxt = gnt_r;
    share_nxt = share_r;
    wleft_nxt = wleft_r;
    rleft_nxt = rleft_r;
    piece_nxt = piece_r;
    addr_nxt = addr_r;
    sa_nxt = sa_r;
    sd_nxt = sd_r;
    sbe_nxt = sbe_r;
    sbc_nxt = sbc_r;
    sr_nxt = sr_r && s_waitrequest;
    sw_nxt = sw_r && s_waitrequest;
    bc = blen(m_burstcount[gnt_r]);
    n = '0;
    issue = 1'h0;
    done = 1'h0;
    wait_nxt = '1;
    case (st_r)
        ST_ARB:
        begin
            if (|req)
            begin
                gnt_nxt = rr_pick(req, gnt_r);
                share_nxt = (share_count[gnt_nxt] == '0) ? ONE_SH
                    : share_count[gnt_nxt];
                st_nxt = ST_XFER;
            end
        end
        ST_XFER:
        begin
            if (take && m_write[gnt_r])
            begin
                if (wleft_r != '0)
                    bc = wleft_r;
                // New piece: regenerate start address and length
                if (piece_r == '0)
                begin
                    n = bmin(bc, lim);
                    sa_nxt = (wleft_r == '0) ? m_address[gnt_r]
                        : addr_r;
                    sbc_nxt = n;
                    piece_nxt = n - ONE_BC;
                end
                else
                    piece_nxt = piece_r - ONE_BC;
                sw_nxt = 1'h1;
                sd_nxt = m_writedata[gnt_r];
                sbe_nxt = m_byteenable[gnt_r];
                addr_nxt = ((wleft_r == '0) ? m_address[gnt_r] : addr_r)
                    + (AW'(1) << WB_SH);
                wleft_nxt = bc - ONE_BC;
                done = (bc == ONE_BC);
            end
            else if (take)
            begin
                rleft_nxt = bc;
                addr_nxt = m_address[gnt_r];
            end
            // Read pieces go out only with room for every word
            if (rleft_r != '0 && sfree && (slave_pipelined || pend_r == '0)
                && int'(pend_r) + int'(bmin(rleft_r, lim)) <= MAXP)
            begin
                n = bmin(rleft_r, lim);
                issue = 1'h1;
                sr_nxt = 1'h1;
                sa_nxt = addr_r;
                sbc_nxt = n;
                addr_nxt = addr_r + (AW'(n) << WB_SH);
                rleft_nxt = rleft_r - n;
                done = (rleft_r == n);
            end
            // One share is one whole burst
            if (done)
            begin
                share_nxt = share_r - ONE_SH;
                if (share_r == ONE_SH)
                    st_nxt = ST_ARB;
            end
            else if (wleft_r == '0 && rleft_r == '0 && !take
                && !req[gnt_r] && |req)
                st_nxt = ST_ARB;
        end
        default:
            st_nxt = ST_ARB;
    endcase
    // Offer one slot; a plain master or plain slave waits out latency
    if (st_nxt == ST_XFER && !sr_nxt && !sw_nxt && rleft_nxt == '0
        && int'(pend_r) < MAXP
        && (slave_pipelined || pend_r == '0)
        && (master_pipelined[gnt_nxt] || mout_r[gnt_nxt] == '0))
        wait_nxt[gnt_nxt] = 1'h0;
end

always_ff @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        st_r <= ST_ARB;
        gnt_r <= '0;
        share_r <= '0;
        wait_r <= '1;
        wleft_r <= '0;
        rleft_r <= '0;
        piece_r <= '0;
        addr_r <= '0;
        sa_r <= '0;
        sr_r <= 1'h0;
        sw_r <= 1'h0;
        sd_r <= '0;
        sbe_r <= '0;
        sbc_r <= '0;
    end
    else
    begin
        st_r <= st_nxt;
        gnt_r <= gnt_nxt;
        share_r <= share_nxt;
        wait_r <= wait_nxt;
        wleft_r <= wleft_nxt;
        rleft_r <= rleft_nxt;
        piece_r <= piece_nxt;
        addr_r <= addr_nxt;
        sa_r <= sa_nxt;
        sr_r <= sr_nxt;
        sw_r <= sw_nxt;
        sd_r <= sd_nxt;
        sbe_r <= sbe_nxt;
        sbc_r <= sbc_nxt;
    end
end

// ============================================================
// Read return: owner tags and per-master response FIFOs
always_comb
begin
    pend_nxt = pend_r + (issue ? CW'(n) : '0) - (ret ? CW'(1) : '0);
    sh_nxt = {sh_r[FLAT-2:0], sr_r && !s_waitrequest && slave_fixed_latency};
    tid_nxt = tid_r;
    tcnt_nxt = tcnt_r;
    twp_nxt = twp_r;
    trp_nxt = trp_r;
    tc_nxt = tc_r;
    rf_nxt = rf_r;
    rwp_nxt = rwp_r;
    rrp_nxt = rrp_r;
    rc_nxt = rc_r;
    rv_nxt = '0;
    rd_nxt = rd_r;
    // Each issued piece records its owner and word count
    if (issue)
    begin
        tid_nxt[twp_r] = gnt_r;
        tcnt_nxt[twp_r] = n;
        twp_nxt = twp_r + PW'(1);
        tc_nxt = tc_nxt + CW'(1);
    end
    if (ret)
    begin
        rf_nxt[tid_r[trp_r]][rwp_r[tid_r[trp_r]]] = s_readdata;
        rwp_nxt[tid_r[trp_r]] = rwp_r[tid_r[trp_r]] + PW'(1);
        rc_nxt[tid_r[trp_r]] = rc_r[tid_r[trp_r]] + CW'(1);
        tcnt_nxt[trp_r] = tcnt_r[trp_r] - ONE_BC;
        if (tcnt_r[trp_r] == ONE_BC)
        begin
            trp_nxt = trp_r + PW'(1);
            tc_nxt = tc_nxt - CW'(1);
        end
    end
    // Masters never stall returns, so each FIFO drains a word a cycle
    for (int i = 0; i < NM; i++)
    begin
        mout_nxt[i] = mout_r[i];
        if (take && m_read[i] && int'(gnt_r) == i)
            mout_nxt[i] = mout_nxt[i] + OW'(bc);
        if (rc_r[i] != '0)
        begin
            rv_nxt[i] = 1'h1;
            rd_nxt[i] = rf_r[i][rrp_r[i]];
            rrp_nxt[i] = rrp_r[i] + PW'(1);
            rc_nxt[i] = rc_nxt[i] - CW'(1);
            mout_nxt[i] = mout_nxt[i] - OW'(1);
        end
    end
end

always_ff @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        pend_r <= '0;
        sh_r <= '0;
        tid_r <= '{default: '0};
        tcnt_r <= '{default: '0};
        twp_r <= '0;
        trp_r <= '0;
        tc_r <= '0;
        rf_r <= '{default: '0};
        rwp_r <= '{default: '0};
        rrp_r <= '{default: '0};
        rc_r <= '{default: '0};
        mout_r <= '{default: '0};
        rv_r <= '0;
        rd_r <= '0;
    end
    else
    begin
        pend_r <= pend_nxt;
        sh_r <= sh_nxt;
        tid_r <= tid_nxt;
        tcnt_r <= tcnt_nxt;
        twp_r <= twp_nxt;
        trp_r <= trp_nxt;
        tc_r <= tc_nxt;
        rf_r <= rf_nxt;
        rwp_r <= rwp_nxt;
        rrp_r <= rrp_nxt;
        rc_r <= rc_nxt;
        mout_r <= mout_nxt;
        rv_r <= rv_nxt;
        rd_r <= rd_nxt;
    end
end

// ============================================================
// Assertions and covers
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!rst_n);

AST_DEFAULT_SHARE: assert property (
    st_r == ST_ARB && |req && share_count[rr_pick(req, gnt_r)] == '0
    |=> share_r == ONE_SH) else $error("default share not one");
AST_SHARE_HOLD: assert property (
    done && share_r > ONE_SH |=> st_r == ST_XFER && $stable(gnt_r))
    else $error("grant lost with shares left");
AST_NO_IDLE: assert property (
    st_r == ST_XFER && wleft_r == '0 && rleft_r == '0 && !take
    && !req[gnt_r] && |req |=> st_r == ST_ARB)
    else $error("idle grant not passed on");
AST_BURST_BEATS: assert property (
    take && m_write[gnt_r] && wleft_r == '0
    |=> wleft_r == $past(bc) - ONE_BC) else $error("beat count wrong");
AST_LOCK_OTHERS: assert property (
    wleft_r != '0 |-> &(m_waitrequest | (NM'(1) << gnt_r)))
    else $error("other master offered during burst");
AST_SEQ_ADDR: assert property (
    take && m_write[gnt_r] && wleft_r != '0
    |=> addr_r == $past(addr_r) + (AW'(1) << WB_SH))
    else $error("burst address not sequential");
AST_PIECE_LEN: assert property (
    (sr_r || sw_r) |-> sbc_r != '0 && sbc_r <= SMAX)
    else $error("slave burst too long");
AST_NP_MASTER: assert property (
    !master_pipelined[gnt_r] && mout_r[gnt_r] != '0
    |-> m_waitrequest[gnt_r]) else $error("plain master not held");
AST_NP_SLAVE: assert property (
    $rose(sr_r) && !slave_pipelined |-> $past(pend_r) == '0)
    else $error("plain slave given overlapping read");
AST_PEND_MAX: assert property (
    int'(pend_r) <= MAXP) else $error("outstanding reads exceeded");

COV_LONG_WRITE: cover property (take && m_write[gnt_r] && bc == 4'h8);
COV_YIELD: cover property (st_r == ST_XFER && !req[gnt_r] && |req
    ##1 st_r == ST_ARB);
COV_FIXED_RET: cover property (slave_fixed_latency && ret);

endmodule : share_burst_slave_arbiter

/* File: pkg/arb_pkg.sv */
// Constants, types and state codes for the shared-slave arbiter.
// Assumes masters, slave and arbiter all run on one clock.
//
// Notes on behaviour
// - Every master defaults to exactly one share
// - Shares per master; grant held while transferring
// - Idle granted master yields to waiting requesters
// - Write burst of N beats keeps grant N beats
// - For bursting masters a share is one burst
// - Grant locked until burst ends, despite stalls
// - Burst beats step one word from base
// - Single transfers may use any address
// - Adapter between long-burst master and slave
// - Non-bursting ports count as burst one
// - Oversized bursts split, address and count regenerated
// - Fixed-latency slave gets pipelined read support
// - Variable-latency returns buffered, sized for outstanding
// - Non-pipelined master waits; slave serves others
// - Pipelined master on plain slave is serialized
// - Fixed-latency data delivered when valid
// - Plain master on plain slave: nothing added
// - Waitrequest when outstanding reads would overflow
// - One response FIFO per master, outstanding-deep
package arb_pkg;
    localparam int NM = 3;
    localparam int IW = 2;
    localparam int AW = 32;
    localparam int DW = 32;
    localparam int BEW = 4;
    localparam int BCW = 4;
    localparam int SHW = 4;
    localparam int OW = 5;
    // Outstanding read words the slave may hold
    localparam int MAXP = 4;
    localparam int PW = 2;
    localparam int CW = 3;
    // Cycles from read acceptance to data, fixed slaves
    localparam int FLAT = 2;
    // Word to byte address shift
    localparam int WB_SH = 2;
    localparam logic [BCW-1:0] SMAX = 4'h2;
    localparam logic [BCW-1:0] ONE_BC = 4'h1;
    localparam logic [SHW-1:0] ONE_SH = 4'h1;
    typedef enum logic {ST_ARB, ST_XFER} arb_st_t;
endpackage : arb_pkg

/* File: testbench/slave_model.sv */
// Behavioural shared slave: stores written words, returns read words.
// Assumes one clock and commands held until the slave takes them.
`timescale 1ns/10ps
module slave_model
    import arb_pkg::*;
(
    // Clock, reset and mode
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic fixed_lat,
    input wire logic piped,
    input wire logic slow,
    // Slave port
    input wire logic [AW-1:0] s_address,
    input wire logic s_read,
    input wire logic s_write,
    input wire logic [DW-1:0] s_writedata,
    input wire logic [BCW-1:0] s_burstcount,
    output logic s_waitrequest,
    output logic [DW-1:0] s_readdata,
    output logic s_readdatavalid
);
    // ==================================================
    // Storage and owed read words
    logic [DW-1:0] mem [logic [AW-1:0]];
    logic [AW-1:0] pend[$];
    logic [AW-1:0] wbase;
    logic [AW-1:0] fx_a;
    logic fx_v;
    int wbeat;
    int tick;
    int maxq;
    // One edge takes, stores, returns and stalls
    always @(posedge ref_clk or negedge rst_n)
    begin : edge_p
        logic tk;
        logic dv;
        logic [AW-1:0] da;
        if (!rst_n)
        begin
            pend.delete();
            wbeat = 0;
            tick = 0;
            fx_v <= 1'b0;
            s_waitrequest <= 1'b0;
            s_readdatavalid <= 1'b0;
            s_readdata <= '0;
        end
        else
        begin
            tk = (s_read || s_write) && !s_waitrequest;
            tick++;
            if (tk && s_write)
            begin
                if (wbeat == 0)
                    wbase = s_address;
                mem[wbase + AW'(4 * wbeat)] = s_writedata;
                wbeat = (wbeat + 1 >= int'(s_burstcount)) ? 0 : wbeat + 1;
            end
            if (tk && s_read && !fixed_lat)
                for (int k = 0; k < int'(s_burstcount); k++)
                    pend.push_back(s_address + AW'(4 * k));
            // Slow mode returns variable-latency words only every fourth cycle
            dv = fixed_lat ? fx_v
                : pend.size() > 0 && !(slow && tick % 4 != 0);
            da = fixed_lat ? fx_a : (dv ? pend.pop_front() : '0);
            maxq = (pend.size() > maxq) ? pend.size() : maxq;
            fx_v <= tk && s_read;
            fx_a <= s_address;
            s_readdatavalid <= dv;
            // Idle data toggles so a stale word never matches
            s_readdata <= dv ? (da ^ 32'h5A5A_0000) : ~s_readdata;
            // Non-pipelined variable-latency slave stalls while it owes a word
            s_waitrequest <= (slow && !s_waitrequest)
                || (!piped && pend.size() > 0);
        end
    end
endmodule : slave_model

/* File: testbench/tb.sv */
// Bench for the shared-slave arbiter: three masters driven here,
// one behavioural slave. Assumes NM is 3.
`timescale 1ns/10ps
module tb
    import arb_pkg::*;
;
    // ==================================================
    // Signals
    logic ref_clk, rst_n, slave_pipelined, slave_fixed_latency, slow;
    logic [NM-1:0][SHW-1:0] share_count;
    logic [NM-1:0] master_pipelined, m_read, m_write;
    logic [NM-1:0] m_waitrequest, m_readdatavalid;
    logic [NM-1:0][AW-1:0] m_address;
    logic [NM-1:0][DW-1:0] m_writedata, m_readdata;
    logic [NM-1:0][BEW-1:0] m_byteenable;
    logic [NM-1:0][BCW-1:0] m_burstcount;
    logic [AW-1:0] s_address;
    logic s_read, s_write, s_waitrequest, s_readdatavalid;
    logic [DW-1:0] s_writedata, s_readdata;
    logic [BEW-1:0] s_byteenable;
    logic [BCW-1:0] s_burstcount;
    int n_errors, checks_done;
    int tl[$];
    logic [DW-1:0] rq[NM][$];

    share_burst_slave_arbiter u_share_burst_slave_arbiter (.*);
    slave_model u_slave_model (.fixed_lat(slave_fixed_latency),
        .piped(slave_pipelined), .*);

    // 25 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Log of takes and returned words per master
    always @(posedge ref_clk)
        for (int i = 0; i < NM; i++)
        begin
            if (m_waitrequest[i] === 1'b0 && (m_read[i] || m_write[i]))
                tl.push_back(i);
            if (m_readdatavalid[i] === 1'b1)
                rq[i].push_back(m_readdata[i]);
        end

    // ==================================================
    // Helpers
    function automatic logic [DW-1:0] wd(input logic [AW-1:0] a);
        return a ^ 32'h0F0F_0000;
    endfunction : wd

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Write burst; hold keeps the request up for a next burst
    task automatic mwr(input int i, input logic [AW-1:0] a, input int n,
        input bit hold, input int gap);
        int k;
        k = 0;
        m_address[i] <= a;
        m_burstcount[i] <= BCW'(n);
        // First word is driven together with the request; later words follow each take
        m_writedata[i] <= wd(a);
        m_write[i] <= 1'b1;
        while (k < n)
        begin
            @(posedge ref_clk);
            if (m_write[i] && m_waitrequest[i] === 1'b0)
            begin
                k++;
                if (k < n)
                    m_writedata[i] <= wd(a + AW'(4 * k));
                if (k == 2 && gap > 0)
                begin
                    m_write[i] <= 1'b0;
                    repeat (gap) @(posedge ref_clk);
                    m_write[i] <= 1'b1;
                end
            end
        end
        if (!hold)
            m_write[i] <= 1'b0;
    endtask : mwr

    task automatic mrd(input int i, input logic [AW-1:0] a, input int n);
        m_address[i] <= a;
        m_burstcount[i] <= BCW'(n);
        m_read[i] <= 1'b1;
        do
            @(posedge ref_clk);
        while (m_waitrequest[i] !== 1'b0);
        m_read[i] <= 1'b0;
    endtask : mrd

    task automatic rchk(input int i, input logic [AW-1:0] a, input int n);
        repeat (300)
            if (rq[i].size() < n)
                @(posedge ref_clk);
        chk("rd_count", n, rq[i].size());
        for (int k = 0; k < n && rq[i].size() > 0; k++)
            chk("rd_data", (a + 4 * k) ^ 32'h5A5A_0000,
                rq[i].pop_front());
        rq[i].delete();
    endtask : rchk

    // ==================================================
    // Scenarios
    task automatic t_burst;
        @(posedge ref_clk);
        slow <= 1'b1;
        tl.delete();
        fork
            mwr(0, 32'h0000_0100, 5, 1'b0, 6);
            begin
                @(posedge ref_clk);
                mwr(1, 32'h0000_0200, 1, 1'b0, 0);
            end
        join
        repeat (20) @(posedge ref_clk);
        chk("takes", 6, tl.size());
        for (int k = 0; k < 6; k++)
            chk("taker", (k < 5) ? 0 : 1, tl[k]);
        for (int k = 0; k < 5; k++)
            chk("wr_mem", wd(32'h100 + 4 * k),
                u_slave_model.mem[32'h100 + 4 * k]);
        chk("byte_en", 32'hF, s_byteenable);
        slow <= 1'b0;
        $display("test burst done");
    endtask : t_burst

    task automatic t_shares;
        int ex [2][4] = '{'{0, 1, 2, 0}, '{0, 0, 1, 2}};
        for (int r = 0; r < 2; r++)
        begin
            share_count[0] <= SHW'(2 * r);
            @(posedge ref_clk);
            tl.delete();
            fork
                begin
                    mwr(0, 32'h0000_0300, 1, 1'b1, 0);
                    // Non-consecutive word gets a burst of its own
                    mwr(0, 32'h0000_0340, 1, 1'b0, 0);
                end
                begin
                    @(posedge ref_clk);
                    fork
                        mwr(1, 32'h0000_0304, 1, 1'b0, 0);
                        mwr(2, 32'h0000_0308, 1, 1'b0, 0);
                    join
                end
            join
            repeat (8) @(posedge ref_clk);
            chk("takes", 4, tl.size());
            for (int k = 0; k < 4; k++)
                chk("taker", ex[r][k], tl[k]);
            chk("wr_mem", wd(32'h340), u_slave_model.mem[32'h340]);
        end
        $display("test shares done");
    endtask : t_shares

    task automatic t_yield;
        time t0;
        share_count[0] <= 4'h4;
        @(posedge ref_clk);
        t0 = $time;
        fork
            mwr(0, 32'h0000_0400, 1, 1'b0, 0);
            begin
                @(posedge ref_clk);
                mwr(1, 32'h0000_0404, 1, 1'b0, 0);
            end
        join
        chk("yield", 1, ($time - t0) <= 12 * 40);
        share_count[0] <= 4'h0;
        $display("test yield done");
    endtask : t_yield

    // Master0 pipelined, slave pipelined, fixed latency
    task automatic t_reads;
        logic [2:0] cf [5] = '{3'h6, 3'h7, 3'h4, 3'h2, 3'h0};
        for (int r = 0; r < 5; r++)
        begin
            @(posedge ref_clk);
            master_pipelined[0] <= cf[r][2];
            slave_pipelined <= cf[r][1];
            slave_fixed_latency <= cf[r][0];
            repeat (2) @(posedge ref_clk);
            fork
                mrd(0, 32'h0000_1000, 3);
                begin
                    @(posedge ref_clk);
                    mrd(1, 32'h0000_2000, 1);
                end
            join
            rchk(0, 32'h0000_1000, 3);
            rchk(1, 32'h0000_2000, 1);
        end
        $display("test reads done");
    endtask : t_reads

    task automatic t_pending;
        @(posedge ref_clk);
        master_pipelined[0] <= 1'b1;
        slave_pipelined <= 1'b1;
        slave_fixed_latency <= 1'b0;
        slow <= 1'b1;
        fork
            mrd(0, 32'h0000_3000, 8);
            begin
                @(posedge ref_clk);
                mrd(1, 32'h0000_4000, 2);
            end
        join
        rchk(0, 32'h0000_3000, 8);
        rchk(1, 32'h0000_4000, 2);
        chk("max_pend", 1, u_slave_model.maxq <= MAXP);
        $display("test pending done");
    endtask : t_pending

    task automatic t_reset_mid;
        m_address[0] <= 32'h0000_5000;
        m_burstcount[0] <= 4'h8;
        m_read[0] <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b0;
        m_read[0] <= 1'b0;
        @(posedge ref_clk);
        chk("wait_rst", 32'h7, m_waitrequest);
        chk("rvalid_rst", 0, m_readdatavalid);
        chk("cmd_rst", 0, {s_read, s_write});
        rst_n <= 1'b1;
        slow <= 1'b0;
        for (int i = 0; i < NM; i++)
            rq[i].delete();
        @(posedge ref_clk);
        mrd(0, 32'h0000_6000, 1);
        rchk(0, 32'h0000_6000, 1);
        $display("test reset done");
    endtask : t_reset_mid

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // ==================================================
    // Main sequence and watchdog
    initial
    begin
        rst_n = 1'b0;
        share_count = '0;
        master_pipelined = '1;
        slave_pipelined = 1'b1;
        slave_fixed_latency = 1'b0;
        slow = 1'b0;
        m_address = '0;
        m_read = '0;
        m_write = '0;
        m_writedata = '0;
        m_byteenable = '1;
        m_burstcount = '0;
        n_errors = 0;
        checks_done = 0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_burst();
        t_shares();
        t_yield();
        t_reads();
        t_pending();
        t_reset_mid();
        summarize();
    end

    // Whole run needs under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        $display("BAD watchdog exp done got hang");
        summarize();
    end
endmodule : tb
